// [hw/cardbus_socket_clock_reset.sv]
`include "socket_clock_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module cardbus_socket_clock_reset #(
  parameter int         AD_W        = `AD_WIDTH,
  parameter logic [3:0] ANNOUNCE_N  = `CLKRUN_ANNOUNCE_CYCLES,
  parameter logic [3:0] LISTEN_N    = `CLKRUN_LISTEN_CYCLES,
  parameter logic [3:0] SLOW_DIV    = `SLOW_DIVIDE
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic            stop_request,
  input  wire logic            slow_request,
  input  wire logic            card_reset_request,
  output logic                 clock_reduced,
  output logic                 card_in_reset,
  input  wire logic            pci_clk,
  output logic                 socket_clock_out,
  output logic                 socket_reset_out_n,
  input  wire logic            socket_clock_run_line_in,
  output logic                 socket_clock_run_line_out,
  output logic                 socket_clock_run_line_oe_n,
  input  wire logic [AD_W-1:0] socket_addr_data_bus_in,
  output logic      [AD_W-1:0] socket_addr_data_bus_out,
  output logic                 socket_addr_data_bus_oe_n,
  input  wire logic [AD_W-1:0] tx_data,
  input  wire logic            tx_drive,
  output logic      [AD_W-1:0] rx_data
);

  typedef struct packed {
    logic       stop_req;
    logic       slow_req;
    logic       rst_req;
    logic [2:0] red_s;
    logic       red_f;
    logic [2:0] socket_reset_out_s;
    logic       socket_reset_out_f;
  } host_type;

  typedef struct packed {
    logic [2:0]                     stop_s;
    logic                           stop_f;
    logic [2:0]                     slow_s;
    logic                           slow_f;
    logic [2:0]                     en_s;
    logic                           en_f;
    logic [2:0]                     run_s;
    logic                           run_f;
    socket_clock_pkg::link_state_type st;
    logic [3:0]                     cnt;
    logic [3:0]                     div;
    logic                           reduced;
    logic                           run_val;
    logic                           run_oe_n;
    logic [AD_W-1:0]                rx;
    logic [AD_W-1:0]                tx;
    logic                           tx_oe_n;
  } link_type;

  host_type h;
  host_type next_h;
  link_type l;
  link_type next_l;
  logic     gate_next;
  logic     gate_q;
  logic     card_rst_n;
  logic     reset_active;
  logic     want_reduce;

  // Filtered level: a change counts once stages two and three agree
  function automatic logic agree(input logic [2:0] s, input logic f);
    return (s[2] == s[1]) ? s[2] : f;
  endfunction : agree

  // Host clock domain: control levels and status back from the link
  always_comb begin
    next_h        = h;
    next_h.red_s  = {h.red_s[1:0], l.reduced};
    next_h.red_f  = agree(h.red_s, h.red_f);
    next_h.socket_reset_out_s = {h.socket_reset_out_s[1:0], reset_active};
    next_h.socket_reset_out_f = agree(h.socket_reset_out_s, h.socket_reset_out_f);
    if (clk_en) begin
      next_h.stop_req = stop_request;
      next_h.slow_req = slow_request;
      next_h.rst_req  = card_reset_request;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  assign clock_reduced = h.red_f;
  assign card_in_reset = h.socket_reset_out_f;
  assign card_rst_n    = rst_n & ~h.rst_req;

  // Link domain
  assign reset_active = ~socket_reset_out_n;
  assign want_reduce  = l.stop_f | l.slow_f;

  always_comb begin
    next_l        = l;
    next_l.stop_s = {l.stop_s[1:0], h.stop_req};
    next_l.stop_f = agree(l.stop_s, l.stop_f);
    next_l.slow_s = {l.slow_s[1:0], h.slow_req};
    next_l.slow_f = agree(l.slow_s, l.slow_f);
    next_l.en_s   = {l.en_s[1:0], clk_en};
    next_l.en_f   = agree(l.en_s, l.en_f);
    // Clock-run is asynchronous to the card clock, so filter it
    next_l.run_s  = {l.run_s[1:0], socket_clock_run_line_in};
    next_l.run_f  = agree(l.run_s, l.run_f);
    if (l.en_f) begin
      if (gate_q) begin
        next_l.rx = socket_addr_data_bus_in;
      end
      // Controller parks the bus while the card floats it
      next_l.tx      = reset_active ? '0 : tx_data;
      next_l.tx_oe_n = reset_active ? 1'b0 : ~tx_drive;
      case (l.st)
        socket_clock_pkg::LINK_RUN: begin
          next_l.run_val  = 1'b0;
          next_l.run_oe_n = 1'b0;
          // Release of reset needs card edges, so stay at full rate
          if (want_reduce && !reset_active) begin
            next_l.st       = socket_clock_pkg::LINK_ANNOUNCE;
            next_l.cnt      = '0;
            next_l.run_val  = 1'b1;
          end
        end
        socket_clock_pkg::LINK_ANNOUNCE: begin
          if (l.cnt != ANNOUNCE_N - 4'h1) begin
            next_l.cnt = l.cnt + 4'h1;
          end
          // Listen only once the filter has seen our own high level,
          // else the low driven while running looks like a card request
          if (!want_reduce || reset_active) begin
            next_l.st       = socket_clock_pkg::LINK_RUN;
            next_l.run_val  = 1'b0;
          end else if (l.cnt == ANNOUNCE_N - 4'h1 && l.run_f) begin
            next_l.st       = socket_clock_pkg::LINK_LISTEN;
            next_l.cnt      = '0;
            next_l.run_oe_n = 1'b1;
          end
        end
        socket_clock_pkg::LINK_LISTEN: begin
          next_l.cnt = l.cnt + 4'h1;
          if (!l.run_f || !want_reduce || reset_active) begin
            next_l.st       = socket_clock_pkg::LINK_RUN;
            next_l.run_val  = 1'b0;
            next_l.run_oe_n = 1'b0;
          end else if (l.cnt == LISTEN_N - 4'h1) begin
            next_l.st      = socket_clock_pkg::LINK_REDUCED;
            next_l.div     = '0;
            next_l.reduced = 1'b1;
          end
        end
        socket_clock_pkg::LINK_REDUCED: begin
          next_l.div = (l.div == SLOW_DIV - 4'h1) ? '0 : l.div + 4'h1;
          if (!l.run_f || !want_reduce || reset_active) begin
            next_l.st       = socket_clock_pkg::LINK_RESTORE;
            next_l.reduced  = 1'b0;
            next_l.run_val  = 1'b0;
            next_l.run_oe_n = 1'b0;
          end
        end
        socket_clock_pkg::LINK_RESTORE: begin
          next_l.st = socket_clock_pkg::LINK_RUN;
        end
        default: begin
          next_l.st = socket_clock_pkg::LINK_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      l          <= '0;
      l.run_f    <= 1'b1;
      l.run_s    <= 3'h7;
      l.tx_oe_n  <= 1'b1;
      l.run_oe_n <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // Full rate everywhere except the reduced state
  always_comb begin
    gate_next = 1'b1;
    if (l.st == socket_clock_pkg::LINK_REDUCED) begin
      gate_next = l.stop_f ? 1'b0 : (l.div == '0);
    end
  end

  card_clock_cell u_cell (
    .pci_clk            (pci_clk),
    .rst_n              (rst_n),
    .card_rst_n         (card_rst_n),
    .gate_next          (gate_next),
    .gate_q             (gate_q),
    .socket_clock_out   (socket_clock_out),
    .socket_reset_out_n (socket_reset_out_n)
  );

  assign socket_clock_run_line_out  = l.run_val;
  assign socket_clock_run_line_oe_n = l.run_oe_n;
  assign socket_addr_data_bus_out   = l.tx;
  assign socket_addr_data_bus_oe_n  = l.tx_oe_n;
  assign rx_data                    = l.rx;

  reduce_after_listen_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (l.st == socket_clock_pkg::LINK_REDUCED &&
     $past(l.st) != socket_clock_pkg::LINK_REDUCED)
    |-> $past(l.st) == socket_clock_pkg::LINK_LISTEN)
    else $error("clock reduced without announce");

  announce_drives_high_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    l.st == socket_clock_pkg::LINK_ANNOUNCE
    |-> !socket_clock_run_line_oe_n && socket_clock_run_line_out)
    else $error("announce not driven on clock run");

  request_restores_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (l.st == socket_clock_pkg::LINK_REDUCED && !l.run_f && l.en_f)
    |=> l.st == socket_clock_pkg::LINK_RESTORE ##1
        l.st == socket_clock_pkg::LINK_RUN)
    else $error("card request did not restore clock");

  request_blocks_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (l.st == socket_clock_pkg::LINK_LISTEN && !l.run_f && l.en_f)
    |=> l.st == socket_clock_pkg::LINK_RUN && !socket_clock_run_line_oe_n)
    else $error("reduction despite card request");

  full_rate_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    l.st != socket_clock_pkg::LINK_REDUCED ##1
    l.st != socket_clock_pkg::LINK_REDUCED |-> gate_q)
    else $error("card clock gated at full rate");

  stop_rests_low_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (l.st == socket_clock_pkg::LINK_REDUCED && l.stop_f) [*2]
    |-> !gate_q && !socket_clock_out)
    else $error("stopped card clock not low");

  release_on_edge_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    $rose(socket_reset_out_n) |-> $past(gate_q, 1))
    else $error("reset released off a card edge");

  reset_parks_bus_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (!socket_reset_out_n && l.en_f) [*2]
    |-> !socket_addr_data_bus_oe_n && socket_addr_data_bus_out == '0)
    else $error("bus not parked during card reset");

  sample_edge_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    (gate_q && l.en_f) |=> rx_data == $past(socket_addr_data_bus_in))
    else $error("bus not sampled on card edge");

  hold_off_edge_a: assert property (
    @(posedge pci_clk) disable iff (!rst_n)
    !gate_q |=> $stable(rx_data))
    else $error("bus sampled without card edge");

endmodule : cardbus_socket_clock_reset

`default_nettype wire

// [hw/socket_clock_regs.svh]
`ifndef SOCKET_CLOCK_REGS_SVH
`define SOCKET_CLOCK_REGS_SVH

// Minimum cycles of the host clock the clock-run line is driven high
`define CLKRUN_ANNOUNCE_CYCLES 4'h3
// Cycles the controller listens for a card objection
`define CLKRUN_LISTEN_CYCLES   4'h8
// Host clock cycles per card clock pulse in slow mode
`define SLOW_DIVIDE            4'h4
// Width of the multiplexed address/data bus
`define AD_WIDTH               32

`endif

// [hw/socket_clock_pkg.sv]
package socket_clock_pkg;

  typedef enum logic [2:0] {
    LINK_RUN,
    LINK_ANNOUNCE,
    LINK_LISTEN,
    LINK_REDUCED,
    LINK_RESTORE
  } link_state_type;

endpackage : socket_clock_pkg

// [hw/card_clock_cell.sv]
`timescale 1ns/1ns
`default_nettype none

module card_clock_cell (
  input  wire logic pci_clk,
  input  wire logic rst_n,
  input  wire logic card_rst_n,
  input  wire logic gate_next,
  output var  logic gate_q,
  output logic      socket_clock_out,
  output var  logic socket_reset_out_n
);

  logic release_stage;

  // Gate changes only while the host clock is low, so no runt pulses
  always_ff @(negedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_next;
    end
  end

  // A stopped card clock always rests low
  assign socket_clock_out = pci_clk & gate_q;

  // Assert at once, release only on a real card clock rising edge
  always_ff @(posedge pci_clk or negedge card_rst_n) begin
    if (!card_rst_n) begin
      release_stage      <= 1'b0;
      socket_reset_out_n <= 1'b0;
    end else if (gate_q) begin
      release_stage      <= 1'b1;
      socket_reset_out_n <= release_stage;
    end
  end

endmodule : card_clock_cell

`default_nettype wire

// [verif/card_socket_model.sv]
`timescale 1ns/1ns
`default_nettype none

module card_socket_model (
  input  wire logic        socket_reset_out_n,
  input  wire logic        want_fast,
  input  wire logic        send,
  input  wire logic [31:0] word,
  output logic             run_pull_n,
  output logic [31:0]      ad_drive,
  output logic             ad_oe_n
);
  // Clock-run pull is not tied to the card clock, which may be stopped
  assign run_pull_n = !(want_fast && socket_reset_out_n);
  // Everything floats while the card is held in reset
  assign ad_oe_n = !(send && socket_reset_out_n);
  assign ad_drive = word;
endmodule : card_socket_model

`default_nettype wire

// [verif/tb_cardbus_socket_clock_reset.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_cardbus_socket_clock_reset;
  logic mclk = 0, pci_clk = 0, rst_n = 0, clk_en = 1;
  logic stop_request = 0, slow_request = 0, card_reset_request = 0;
  logic clock_reduced, card_in_reset, socket_clock_out, socket_reset_out_n;
  logic run_out, run_oe_n, run_pull_n, ad_oe_n, card_oe_n;
  logic tx_drive = 0, want_fast = 0, send = 0, saw_ann = 0;
  logic [31:0] ad_out, card_d, rx_data, tx_data = 0, word = 0;
  logic [31:0] ad_idle = 32'h5555_5555;
  int err_count = 0, samples_checked = 0, edges = 0, i;
  wire run_wire = (run_oe_n ? 1'b1 : run_out) & run_pull_n;
  wire [31:0] ad_wire = !ad_oe_n ? ad_out : (!card_oe_n ? card_d : ad_idle);

  cardbus_socket_clock_reset cardbus_socket_clock_reset_inst (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .stop_request(stop_request), .slow_request(slow_request),
    .card_reset_request(card_reset_request),
    .clock_reduced(clock_reduced), .card_in_reset(card_in_reset),
    .pci_clk(pci_clk), .socket_clock_out(socket_clock_out),
    .socket_reset_out_n(socket_reset_out_n),
    .socket_clock_run_line_in(run_wire),
    .socket_clock_run_line_out(run_out),
    .socket_clock_run_line_oe_n(run_oe_n),
    .socket_addr_data_bus_in(ad_wire), .socket_addr_data_bus_out(ad_out),
    .socket_addr_data_bus_oe_n(ad_oe_n),
    .tx_data(tx_data), .tx_drive(tx_drive), .rx_data(rx_data));

  card_socket_model card_socket_model_inst (
    .socket_reset_out_n(socket_reset_out_n), .want_fast(want_fast),
    .send(send), .word(word), .run_pull_n(run_pull_n),
    .ad_drive(card_d), .ad_oe_n(card_oe_n));

  initial forever #50 mclk = ~mclk;
  initial begin
    #7;
    forever #15 pci_clk = ~pci_clk;
  end
  // Released bus must not keep its last value
  always @(posedge pci_clk) ad_idle <= ~ad_idle;
  always @(posedge socket_clock_out) edges++;
  always @(posedge pci_clk) if (!run_oe_n && run_out === 1'b1) saw_ann = 1;

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wait_reduced(logic lvl);
    for (i = 0; i < 300 && clock_reduced !== lvl; i++) @(negedge mclk);
  endtask : wait_reduced

  task automatic t_reset;
    card_reset_request = 1;
    // Status comes back through a three-stage filter
    repeat (5) @(negedge mclk);
    chk("socket_reset_out", 0, socket_reset_out_n);
    chk("in_reset", 1, card_in_reset);
    chk("bus_park_oe", 0, ad_oe_n);
    chk("bus_park", 0, ad_out);
    card_reset_request = 0;
    @(posedge socket_reset_out_n);
    #1 chk("release_edge", 1, socket_clock_out);
    repeat (10) @(negedge mclk);
    chk("in_reset_off", 0, card_in_reset);
  endtask : t_reset

  task automatic t_bus;
    tx_data = 32'h8000_0001;
    tx_drive = 1;
    repeat (3) @(negedge mclk);
    chk("bus_out", 32'h8000_0001, ad_out);
    chk("bus_oe", 0, ad_oe_n);
    tx_drive = 0;
    word = 32'hC001_D00D;
    send = 1;
    repeat (3) @(negedge mclk);
    chk("rx", 32'hC001_D00D, rx_data);
    send = 0;
  endtask : t_bus

  task automatic t_stop_wake;
    saw_ann = 0;
    stop_request = 1;
    wait_reduced(1);
    chk("stopped", 1, clock_reduced);
    chk("announce", 1, saw_ann);
    edges = 0;
    repeat (5) @(negedge mclk);
    chk("stop_edges", 0, edges);
    chk("stop_low", 0, socket_clock_out);
    want_fast = 1;
    wait_reduced(0);
    chk("wake", 0, clock_reduced);
    edges = 0;
    repeat (3) @(negedge mclk);
    chk("wake_runs", 1, edges >= 9);
    want_fast = 0;
    stop_request = 0;
    repeat (10) @(negedge mclk);
  endtask : t_stop_wake

  task automatic t_refuse;
    stop_request = 1;
    // Object while the line is released for listening
    for (i = 0; i < 100 && run_oe_n !== 1'b1; i++) @(negedge mclk);
    want_fast = 1;
    repeat (40) @(negedge mclk);
    chk("refused", 0, clock_reduced);
    chk("listen_abort", 0, run_oe_n);
    stop_request = 0;
    want_fast = 0;
    repeat (10) @(negedge mclk);
  endtask : t_refuse

  task automatic t_slow;
    slow_request = 1;
    wait_reduced(1);
    edges = 0;
    repeat (12) @(negedge mclk);
    // 1200 ns is 40 host periods, one pulse in four
    chk("slow_edges", 1, edges >= 9 && edges <= 11);
    slow_request = 0;
    wait_reduced(0);
    chk("slow_off", 0, clock_reduced);
  endtask : t_slow

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1;
    repeat (5) @(negedge mclk);
    chk("post_reset_socket_reset_out", 1, socket_reset_out_n);
    t_reset();
    t_bus();
    t_stop_wake();
    t_refuse();
    t_slow();
    report_and_stop();
  end

  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule : tb_cardbus_socket_clock_reset

`default_nettype wire
